/* core/rx_los_clk_sel.sv */
// Module: reference clock selection, receiver power control and per channel loss detection
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module rx_los_clk_sel
	import los_pkg::*;
(
	// Clock and reset
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	// Register bus
	input  wire apb_req_t            apb_i,
	output apb_rsp_t                 apb_o,
	// Hardware mode straps, asynchronous
	input  wire strap_t              strap_i,
	// Analog front end, asynchronous
	input  wire logic [NUM_CH-1:0]   analog_loss_i,
	// Recovered data from clock recovery, this clock domain
	input  wire logic [NUM_CH-1:0]   rx_bit_i,
	input  wire logic [NUM_CH-1:0]   rx_bit_valid_i,
	input  wire logic [NUM_CH-1:0]   rx_viol_i,
	// Receive outputs
	output logic [NUM_CH-1:0]        rx_positive_data_out_o,
	output logic [NUM_CH-1:0]        rx_negative_violation_out_o,
	output logic [NUM_CH-1:0]        rx_signal_loss_o,
	// Clock synthesizer and receiver control
	output logic                     ref_use_t1_input_o,
	output logic [2:0]               synth_ref_code_o,
	output logic                     master_rate_select_o,
	output logic [NUM_CH-1:0]        rx_enable_o,
	// Interrupt
	output logic                     interrupt_n_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_CH-1:0]             aloss_s1;   // First synchroniser stage
		logic [NUM_CH-1:0]             aloss_s2;   // Synchronised analog loss
		strap_t                        strap_s1;   // First synchroniser stage
		strap_t                        strap_s2;   // Synchronised straps
		logic [CTRL_W-1:0]             ctrl;       // Host control bits
		logic [NUM_CH-1:0]             los;        // Live loss indication
		logic [NUM_CH-1:0]             alarm;      // Latched loss status
		logic [NUM_CH-1:0]             mask;       // Interrupt enables
		logic [NUM_CH-1:0][CNT_W-1:0]  zcnt;       // Consecutive zero run
		logic [NUM_CH-1:0][CNT_W-1:0]  wcnt;       // Bits into clearing window
		logic [NUM_CH-1:0][CNT_W-1:0]  ones;       // Ones in clearing window
		logic [NUM_CH-1:0]             dout;       // Data output
		logic [NUM_CH-1:0]             vout;       // Violation output
		logic                          irq_n;      // Registered interrupt
	} state_t;

	state_t st_reg;                            // Current state
	state_t st_next;                           // Next state

	// Effective settings after the host/hardware choice
	logic              host_sel;               // Host mode active
	logic [2:0]        eff_ref;                // Reference select code
	logic              eff_rate;               // Master rate
	logic              eff_ext;                // Extended loss
	logic              eff_t1;                 // T1 line rate
	logic              eff_pwr;                // Receivers on
	logic [CNT_W-1:0]  loss_thr;               // Zeros before declare
	logic [CNT_W-1:0]  win_bits;               // Clearing window length
	logic [CNT_W-1:0]  win_ones;               // Ones needed in window
	logic [CNT_W-1:0]  max_run;                // Longest zero run allowed
	logic              rd_access;              // APB read access phase
	logic              wr_access;              // APB write access phase
	logic [31:0]       rdata;                  // Read mux

	// ----------------------------------------------------------------
	// Settings and bus decode
	// ----------------------------------------------------------------
	// Picks register or strap settings and the per-rate criteria
	always_comb
	begin
		host_sel  = st_reg.strap_s2.host_mode;
		if (host_sel)
		begin
			// Host mode: control bits win over pins
			eff_ref  = st_reg.ctrl[CTRL_REF_LSB +: 3];
			eff_rate = st_reg.ctrl[CTRL_RATE_BIT];
			eff_ext  = st_reg.ctrl[CTRL_EXT_BIT];
			eff_t1   = st_reg.ctrl[CTRL_T1_BIT];
			eff_pwr  = st_reg.ctrl[CTRL_PWR_BIT];
		end
		else
		begin
			// Hardware mode: straps drive everything
			eff_ref  = st_reg.strap_s2.ref_freq_select;
			eff_rate = st_reg.strap_s2.master_rate_select;
			eff_ext  = st_reg.strap_s2.extended_loss_enable;
			eff_t1   = st_reg.strap_s2.t1_mode;
			eff_pwr  = st_reg.strap_s2.receiver_power_on;
		end
		// One rate for every channel
		if (eff_t1)
		begin
			loss_thr = T1_LOSS_ZEROS;
			win_bits = T1_WIN_BITS;
			win_ones = T1_WIN_ONES;
			max_run  = T1_MAX_RUN;
		end
		else
		begin
			loss_thr = eff_ext ? E1_EXT_LOSS_ZEROS : E1_LOSS_ZEROS;
			win_bits = E1_WIN_BITS;
			win_ones = E1_WIN_ONES;
			max_run  = E1_MAX_RUN;
		end
		rd_access = apb_i.psel && apb_i.penable && !apb_i.pwrite;
		wr_access = apb_i.psel && apb_i.penable && apb_i.pwrite;
		// Read mux, narrower registers sit in the low bits
		case (apb_i.paddr)
			ADDR_CTRL:  rdata = {25'h0000000, st_reg.ctrl};
			ADDR_LIVE:  rdata = {24'h000000, st_reg.los};
			ADDR_ALARM: rdata = {24'h000000, st_reg.alarm};
			ADDR_MASK:  rdata = {24'h000000, st_reg.mask};
			default:    rdata = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Synchronisers, registers, loss detectors and interrupt
	always_comb
	begin
		logic [NUM_CH-1:0] rise;               // Loss declared this cycle
		logic              aloss;              // Analog loss, synchronised
		logic              run_bad;            // Zero run too long
		rise    = '0;
		aloss   = 1'b0;
		run_bad = 1'b0;
		st_next = st_reg;
		// Two flip-flops on every asynchronous input
		st_next.aloss_s1 = analog_loss_i;
		st_next.aloss_s2 = st_reg.aloss_s1;
		st_next.strap_s1 = strap_i;
		st_next.strap_s2 = st_reg.strap_s1;

		for (int c = 0; c < NUM_CH; c++)
		begin
			// Analog flag already carries the 9 dB / 3 dB hysteresis
			aloss = st_reg.aloss_s2[c];
			// A lower threshold after a mode change pulls the run back
			if (st_reg.zcnt[c] > loss_thr)
				st_next.zcnt[c] = loss_thr;
			if (rx_bit_valid_i[c])
			begin
				// Pass recovered data to the outputs
				st_next.dout[c] = rx_bit_i[c];
				st_next.vout[c] = rx_viol_i[c];
				// Zero run: a one ends it, saturate at threshold
				if (rx_bit_i[c])
					st_next.zcnt[c] = '0;
				else if (st_reg.zcnt[c] < loss_thr)
					st_next.zcnt[c] = st_reg.zcnt[c] + 13'h0001;
			end
			if (!st_reg.los[c])
			begin
				// Counting only under analog loss
				if (!aloss)
					st_next.zcnt[c] = '0;
				else if (st_next.zcnt[c] >= loss_thr)
				begin
					// Declare loss
					st_next.los[c]  = 1'b1;
					rise[c]         = 1'b1;
					st_next.wcnt[c] = '0;
					st_next.ones[c] = '0;
				end
			end
			else if (!aloss)
			begin
				// Analog level recovered: check ones density windows
				if (rx_bit_valid_i[c])
				begin
					run_bad = st_next.zcnt[c] > max_run;
					if (rx_bit_i[c] && st_reg.ones[c] < win_ones)
						st_next.ones[c] = st_reg.ones[c] + 13'h0001;
					st_next.wcnt[c] = st_reg.wcnt[c] + 13'h0001;
					if (run_bad)
					begin
						// Run too long: restart window
						st_next.wcnt[c] = '0;
						st_next.ones[c] = '0;
					end
					else if (st_next.wcnt[c] == win_bits)
					begin
						// Window complete
						if (st_next.ones[c] >= win_ones)
							st_next.los[c] = 1'b0;
						st_next.wcnt[c] = '0;
						st_next.ones[c] = '0;
					end
				end
			end
			else
			begin
				// Analog loss still present: hold window at start
				st_next.wcnt[c] = '0;
				st_next.ones[c] = '0;
			end
		end

		// Register writes and clear on read
		if (wr_access)
		begin
			case (apb_i.paddr)
				ADDR_CTRL:  st_next.ctrl  = apb_i.pwdata[CTRL_W-1:0];
				ADDR_ALARM: st_next.alarm = st_reg.alarm & ~apb_i.pwdata[NUM_CH-1:0];
				ADDR_MASK:  st_next.mask  = apb_i.pwdata[NUM_CH-1:0];
				default:    st_next.ctrl  = st_reg.ctrl;
			endcase
		end
		else if (rd_access && apb_i.paddr == ADDR_ALARM)
			st_next.alarm = '0;
		// New events win over any clear
		st_next.alarm = st_next.alarm | rise;
		// Interrupt low while an enabled alarm stands
		st_next.irq_n = ~|(st_next.alarm & st_next.mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Single clocked process for all state
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg       <= '0;
			st_reg.ctrl  <= CTRL_RESET;
			st_reg.irq_n <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign apb_o.prdata  = rdata;
	assign apb_o.pready  = 1'b1;              // Zero wait states
	assign apb_o.pslverr = apb_i.psel && apb_i.penable && (apb_i.paddr != ADDR_CTRL)
	                       && (apb_i.paddr != ADDR_LIVE) && (apb_i.paddr != ADDR_ALARM)
	                       && (apb_i.paddr != ADDR_MASK);
	assign rx_positive_data_out_o      = st_reg.dout;
	assign rx_negative_violation_out_o = st_reg.vout;
	assign rx_signal_loss_o            = st_reg.los;
	assign interrupt_n_o               = st_reg.irq_n;
	// Reference input and synthesizer code
	assign ref_use_t1_input_o   = (eff_ref == REF_CODE_1544);
	assign synth_ref_code_o     = eff_ref;
	assign master_rate_select_o = eff_rate;
	assign rx_enable_o          = {NUM_CH{eff_pwr}};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	power_follows_pin_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!st_reg.strap_s2.host_mode |-> rx_enable_o == {NUM_CH{st_reg.strap_s2.receiver_power_on}})
		else $error("receiver enable does not follow power pin");

	ref_input_pick_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		ref_use_t1_input_o |-> synth_ref_code_o == REF_CODE_1544)
		else $error("T1 reference input used with wrong code");

	host_rate_src_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		st_reg.strap_s2.host_mode |-> master_rate_select_o == st_reg.ctrl[CTRL_RATE_BIT])
		else $error("host mode rate not from control bit");

	data_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		rx_bit_valid_i[0] |=> rx_positive_data_out_o[0] == $past(rx_bit_i[0]))
		else $error("recovered data not passed to output");

	loss_needs_run_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(rx_signal_loss_o[0]) |-> $past(st_reg.zcnt[0]) + 13'h0001 >= loss_thr
		&& $past(st_reg.aloss_s2[0]))
		else $error("loss declared without full zero run");

	e1_declare_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!eff_t1 && !eff_ext && !st_reg.los[1] && st_reg.aloss_s2[1] && rx_bit_valid_i[1]
		&& !rx_bit_i[1] && st_reg.zcnt[1] == 13'h001F |=> rx_signal_loss_o[1])
		else $error("E1 loss not declared at 32 zeros");

	clear_needs_level_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(rx_signal_loss_o[0]) |-> !$past(st_reg.aloss_s2[0])
		&& $past(st_reg.ones[0]) + 13'h0001 >= win_ones)
		else $error("loss cleared without level or density");

	alarm_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(rx_signal_loss_o[2]) |-> st_reg.alarm[2])
		else $error("loss event not latched");

	irq_assert_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(rx_signal_loss_o[0]) && st_reg.mask[0] |=> !interrupt_n_o)
		else $error("enabled alarm did not pull interrupt low");

	read_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_access && apb_i.paddr == ADDR_ALARM && st_next.los == st_reg.los
		|=> st_reg.alarm == '0 ##1 interrupt_n_o || st_reg.alarm != '0)
		else $error("alarm read did not clear status");

	zero_sat_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		st_reg.zcnt[0] <= loss_thr || $changed(loss_thr))
		else $error("zero counter passed its threshold");

endmodule // rx_los_clk_sel

/* core/los_pkg.sv */
// Package: register map, field layout, thresholds and carrier types for the loss detector
package los_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 8;                         // Line channels
	localparam int CNT_W  = 13;                        // Counter width, holds 4096

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;        // Control bits
	localparam logic [7:0] ADDR_LIVE  = 8'h04;        // Live loss indication
	localparam logic [7:0] ADDR_ALARM = 8'h08;        // Latched loss status
	localparam logic [7:0] ADDR_MASK  = 8'h0C;        // Interrupt enables

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_W        = 7;                  // Implemented control bits
	localparam int CTRL_REF_LSB  = 0;                  // ref_freq_select [2:0]
	localparam int CTRL_RATE_BIT = 3;                  // master_rate_select
	localparam int CTRL_EXT_BIT  = 4;                  // extended_loss_enable
	localparam int CTRL_T1_BIT   = 5;                  // 1 = T1/J1 rate, 0 = E1
	localparam int CTRL_PWR_BIT  = 6;                  // receiver_power_on
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h40;  // Receivers on, E1, 2048 ref

	// ----------------------------------------------------------------
	// Reference select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] REF_CODE_2048 = 3'h0;       // 2048 kHz on the E1 input
	localparam logic [2:0] REF_CODE_1544 = 3'h1;       // 1544 kHz on the T1 input

	// ----------------------------------------------------------------
	// Loss declare and clear criteria, in received bits
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] E1_LOSS_ZEROS     = 13'h0020;  // 32 zeros
	localparam logic [CNT_W-1:0] E1_EXT_LOSS_ZEROS = 13'h1000;  // 4096 zeros
	localparam logic [CNT_W-1:0] T1_LOSS_ZEROS     = 13'h00AF;  // 175 zeros
	localparam logic [CNT_W-1:0] E1_WIN_BITS       = 13'h0020;  // 32 bit window
	localparam logic [CNT_W-1:0] E1_WIN_ONES       = 13'h0004;  // 4 ones
	localparam logic [CNT_W-1:0] E1_MAX_RUN        = 13'h0010;  // 16 zeros
	localparam logic [CNT_W-1:0] T1_WIN_BITS       = 13'h0080;  // 128 bit window
	localparam logic [CNT_W-1:0] T1_WIN_ONES       = 13'h0010;  // 16 ones
	localparam logic [CNT_W-1:0] T1_MAX_RUN        = 13'h0064;  // 100 zeros

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	// Hardware mode strap pins
	typedef struct packed {
		logic       host_mode;            // 1 = take settings from registers
		logic [2:0] ref_freq_select;
		logic       master_rate_select;
		logic       extended_loss_enable;
		logic       t1_mode;
		logic       receiver_power_on;
	} strap_t;

endpackage

/* tb/line_model.sv */
// Line side model: analog loss flags and recovered bit strobes for all channels
`timescale 1ns/10ps
module line_model
	import los_pkg::*;
(
	// Clock
	input  wire logic         mclk_i,
	// Analog flag and recovered stream
	output logic [NUM_CH-1:0] analog_loss_o,
	output logic [NUM_CH-1:0] rx_bit_o,
	output logic [NUM_CH-1:0] rx_bit_valid_o,
	output logic [NUM_CH-1:0] rx_viol_o
);
	// Quiet line at time zero
	initial
	begin
		analog_loss_o  = '0;
		rx_bit_o       = '0;
		rx_bit_valid_o = '0;
		rx_viol_o      = '0;
	end

	// Analog detector verdict, changed just after an edge
	task automatic set_analog(input logic [NUM_CH-1:0] v);
		@(posedge mclk_i);
		analog_loss_o <= v;
	endtask

	// Back to back bits, same stream and rate on every channel; a one every k-th bit
	task automatic send_bits(input int n, input int k, input logic viol);
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk_i);
			rx_bit_valid_o <= '1;
			rx_bit_o       <= {NUM_CH{(k != 0) && (i % k == 0)}};
			rx_viol_o      <= {NUM_CH{viol}};
		end
		@(posedge mclk_i);
		// Idle lines show the inverse so a stale bit never looks valid
		rx_bit_valid_o <= '0;
		rx_bit_o       <= ~rx_bit_o;
		rx_viol_o      <= ~rx_viol_o;
	endtask
endmodule // line_model

/* tb/rx_los_clk_sel_tb.sv */
// Self-checking bench for loss detection, clock selection and receiver power
`timescale 1ns/10ps
module rx_los_clk_sel_tb
	import los_pkg::*;
();
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic              mclk_i = 1'b0;     // 125 MHz
	logic              rst_i  = 1'b1;     // Async reset
	apb_req_t          apb_i  = '0;       // Bus request
	apb_rsp_t          apb_o;             // Bus answer
	strap_t            strap_i = '0;      // Hardware mode pins
	logic [NUM_CH-1:0] aloss, rbit, rvalid, rviol, pos_out, neg_out, los, rx_en;
	logic              use_t1, rate_o, irq_n;
	logic [2:0]        ref_code;
	logic [31:0]       rd;                // Last read data
	logic              err;               // Last slave error
	int                num_errors = 0;
	int                n_compared = 0;

	always #4 mclk_i = ~mclk_i;

	line_model line (.mclk_i(mclk_i), .analog_loss_o(aloss), .rx_bit_o(rbit),
		.rx_bit_valid_o(rvalid), .rx_viol_o(rviol));

	rx_los_clk_sel uut (.mclk_i(mclk_i), .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o),
		.strap_i(strap_i), .analog_loss_i(aloss), .rx_bit_i(rbit), .rx_bit_valid_i(rvalid),
		.rx_viol_i(rviol), .rx_positive_data_out_o(pos_out),
		.rx_negative_violation_out_o(neg_out), .rx_signal_loss_o(los),
		.ref_use_t1_input_o(use_t1), .synth_ref_code_o(ref_code),
		.master_rate_select_o(rate_o), .rx_enable_o(rx_en), .interrupt_n_o(irq_n));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int i;
		@(posedge mclk_i);
		apb_i.psel    <= 1'b1;
		apb_i.penable <= 1'b0;
		apb_i.pwrite  <= wr;
		apb_i.paddr   <= addr;
		apb_i.pwdata  <= wdata;
		@(posedge mclk_i);
		apb_i.penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge mclk_i);
			if (apb_o.pready === 1'b1)
				break;
		end
		if (i == 16)
		begin
			num_errors++;
			summarize();
		end
		rd = apb_o.prdata;
		err = apb_o.pslverr;
		apb_i.psel    <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'(CTRL_RESET));
		apb(1'b0, ADDR_ALARM, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ADDR_MASK, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask

	task automatic t_power();
		strap_i.receiver_power_on <= 1'b1;
		repeat (4) @(posedge mclk_i);
		#1 chk(32'(rx_en), 32'hFF);
		@(posedge mclk_i);
		strap_i.receiver_power_on <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1 chk(32'(rx_en), 32'h0);
		@(posedge mclk_i);
	endtask

	// Every select code in host mode while the pins hold code 7 and rate 1
	task automatic t_clock();
		logic [2:0] code;
		// A lone board reference feeds both inputs, so any pick is clocked
		strap_i.host_mode          <= 1'b1;
		strap_i.ref_freq_select    <= 3'h7;
		strap_i.master_rate_select <= 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			code = c[2:0];
			apb(1'b1, ADDR_CTRL, 32'h40 | (32'(code[1]) << CTRL_RATE_BIT) | 32'(code));
			#1 chk(32'(ref_code), 32'(code));
			chk(32'(rate_o), 32'(code[1]));
			chk(32'(use_t1), 32'(code == 3'h1));
		end
	endtask

	task automatic t_e1_declare();
		apb(1'b1, ADDR_CTRL, 32'h40);
		line.set_analog('1);
		repeat (4) @(posedge mclk_i);
		line.send_bits(31, 0, 1'b0);
		line.send_bits(1, 1, 1'b0);
		line.send_bits(31, 0, 1'b0);
		#1 chk(32'(los), 32'h0);
		line.send_bits(1, 0, 1'b0);
		#1 chk(32'(los), 32'hFF);
		@(posedge mclk_i);
		#1 chk(32'(irq_n), 32'h1);
		apb(1'b1, ADDR_MASK, 32'h1);
		@(posedge mclk_i);
		#1 chk(32'(irq_n), 32'h0);
		apb(1'b1, ADDR_LIVE, 32'h0);
		apb(1'b0, ADDR_LIVE, 32'h0);
		chk(rd, 32'hFF);
		apb(1'b0, ADDR_ALARM, 32'h0);
		chk(rd, 32'hFF);
		@(posedge mclk_i);
		#1 chk(32'(irq_n), 32'h1);
		apb(1'b0, ADDR_ALARM, 32'h0);
		chk(rd, 32'h0);
	endtask

	// Clear needs level recovery and the density window; sparse ones must not clear
	task automatic t_clear(input int win, input int sparse);
		line.send_bits(2 * win, 8, 1'b0);
		#1 chk(32'(los), 32'hFF);
		line.set_analog('0);
		repeat (4) @(posedge mclk_i);
		line.send_bits(3 * win, sparse, 1'b0);
		#1 chk(32'(los), 32'hFF);
		// Enough ones for the window, but then a zero run past the limit
		line.send_bits(win / 8, 1, 1'b0);
		line.send_bits(win - win / 8, 0, 1'b0);
		#1 chk(32'(los), 32'hFF);
		line.send_bits(2 * win, 8, 1'b0);
		#1 chk(32'(los), 32'h0);
	endtask

	task automatic t_declare(input logic [31:0] ctrl, input int zeros);
		apb(1'b1, ADDR_CTRL, ctrl);
		line.set_analog('1);
		repeat (4) @(posedge mclk_i);
		line.send_bits(zeros - 1, 0, 1'b0);
		#1 chk(32'(los), 32'h0);
		line.send_bits(1, 0, 1'b0);
		#1 chk(32'(los), 32'hFF);
	endtask

	task automatic t_data();
		line.send_bits(1, 1, 1'b0);
		#1 chk({16'h0, pos_out, neg_out}, 32'hFF00);
		line.send_bits(1, 0, 1'b1);
		#1 chk({16'h0, pos_out, neg_out}, 32'h00FF);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset();
		t_power();
		t_clock();
		t_data();
		t_e1_declare();
		t_clear(32, 11);
		t_declare(32'h60, 175);
		t_clear(128, 9);
		t_declare(32'h50, 4096);
		summarize();
	end
endmodule // rx_los_clk_sel_tb
